//--- shared/config_port_params.svh
// Constants for the configuration data port
`ifndef CONFIG_PORT_PARAMS_SVH
`define CONFIG_PORT_PARAMS_SVH
`define ADDR_LOW_WIDTH 18
`define ADDR_HIGH_WIDTH 4
`define DATA_WIDTH 8
`define STATUS_BIT 7
`define BITS_PER_BYTE 4'h8
`define BIT_COUNT_ZERO 4'h0
`define ADDR_ZERO 22'h000000
`define ADDR_STEP 22'h000001
`define BYTE_ZERO 8'h00
`define LOW_BITS_HIGH 7'h7F
// Synchroniser reset levels, clock pin idles low
`define SYNC_IDLE 14'h3DFF
`endif

//--- shared/config_port_pkg.sv
// Types for the configuration data port
package config_port_pkg;
  typedef enum logic [2:0] {
    MODE_SLAVE_SERIAL,
    MODE_MASTER_SERIAL,
    MODE_MASTER_PARALLEL,
    MODE_PERIPHERAL,
    MODE_EXPRESS
  } config_mode_type;
endpackage : config_port_pkg

//--- logic/pin_sync.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          stage[i]    <= RESET_VALUE[i];
          sync_out[i] <= RESET_VALUE[i];
        end else begin
          stage[i]    <= async_in[i];
          sync_out[i] <= stage[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

//--- logic/config_data_port.sv
// Configuration data port: peripheral, parallel, serial and daisy chain paths
`timescale 1ns/10ps
`default_nettype none
`include "config_port_params.svh"

// Overview of operation
// - selected only while select_low_input is low and select_high_input is high.
// - a low write strobe while selected and not busy captures the data byte into the buffer.
// - selected with read strobe low drives the top data bit as ready high, busy low.
// - during a status read the seven lower data bits are driven high.
// - strobes should be exclusive; if both are low the write wins and the read is ignored.
// - in express mode select_high_input acts as serial enable from upstream.
// - master parallel drives an 18-bit eprom address.
// - wide variants drive 4 more high address bits above the 18.
// - master parallel and peripheral modes take data on data inputs 7 to 1 plus the serial input.
// - serial modes sample serial input on each rising config_clock edge.
// - in parallel modes the serial input pin is bit zero of the data byte.
// - all modes but express offer a serial output for downstream devices.
// - serial output changes on falling config_clock edges 1.5 periods after input.
// - in express mode the serial output pin carries a downstream enable status.
// - after configuration all these pins are released to user I/O.
module config_data_port #(
  parameter bit WIDE_ADDRESS = 1'b1
) (
  input  wire logic                           clock,
  input  wire logic                           sys_rst,
  input  wire config_port_pkg::config_mode_type mode,
  input  wire logic                           config_done,
  input  wire logic                           config_clock,
  input  wire logic                           select_low_input,
  input  wire logic                           select_high_input,
  input  wire logic                           write_strobe_n,
  input  wire logic                           read_strobe_n,
  input  wire logic [`DATA_WIDTH-1:0]         data_in,
  input  wire logic                           serial_in,
  input  wire logic                           express_done,
  output logic      [`DATA_WIDTH-1:0]         data_out,
  output logic      [`DATA_WIDTH-1:0]         data_oe,
  output logic      [`ADDR_LOW_WIDTH-1:0]     eprom_address_low,
  output logic                                address_low_oe,
  output logic      [`ADDR_HIGH_WIDTH-1:0]    eprom_address_high,
  output logic                                address_high_oe,
  output logic                                serial_out,
  output logic                                serial_out_oe,
  output logic      [`DATA_WIDTH-1:0]         config_byte,
  output logic                                config_byte_valid
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [13:0] pins_sync;
  logic        sel_low_s, sel_high_s, ws_s, rs_s, config_clock_s, din_s;
  logic [6:0]  d_hi_s;

  pin_sync #(.WIDTH(14), .RESET_VALUE(`SYNC_IDLE)) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({select_low_input, select_high_input, write_strobe_n, read_strobe_n,
                config_clock, serial_in, data_in[7:1], 1'b1} ),
    .sync_out (pins_sync)
  );
  assign {sel_low_s, sel_high_s, ws_s, rs_s, config_clock_s, din_s, d_hi_s} = pins_sync[13:1];

  // ****************************************************************
  // Mode decode and edges
  // ****************************************************************
  logic is_serial, is_parallel, is_periph, is_master_par, is_express, active;
  logic config_clock_q, config_clock_rise, config_clock_fall;
  logic [`DATA_WIDTH-1:0] byte_in;

  assign active        = !config_done;
  assign is_express    = active && mode == config_port_pkg::MODE_EXPRESS;
  assign is_master_par = active && mode == config_port_pkg::MODE_MASTER_PARALLEL;
  assign is_periph     = active && mode == config_port_pkg::MODE_PERIPHERAL;
  assign is_parallel   = is_master_par || is_periph;
  assign is_serial     = active && (mode == config_port_pkg::MODE_SLAVE_SERIAL
                                    || mode == config_port_pkg::MODE_MASTER_SERIAL);
  assign byte_in       = {d_hi_s, din_s};

  always_ff @(posedge clock) begin
    if (sys_rst) config_clock_q <= 1'b0;
    else config_clock_q <= config_clock_s;
  end
  assign config_clock_rise = config_clock_s && !config_clock_q;
  assign config_clock_fall = !config_clock_s && config_clock_q;

  // ****************************************************************
  // Peripheral write and status
  // ****************************************************************
  logic selected, write_hit, read_hit, ws_q, write_edge, busy;
  logic [`DATA_WIDTH-1:0] par_shift;
  logic [3:0]             par_count;
  logic                   par_loaded;

  assign selected   = is_periph && !sel_low_s && sel_high_s;
  assign write_hit  = selected && !ws_s;
  assign read_hit   = selected && !rs_s && ws_s;
  assign write_edge = write_hit && ws_q;

  always_ff @(posedge clock) begin
    if (sys_rst) ws_q <= 1'b1;
    else ws_q <= ws_s || !selected;
  end

  // Busy while the held byte is still being shifted out
  assign busy = par_loaded;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      data_out <= `BYTE_ZERO;
      data_oe  <= `BYTE_ZERO;
    end else if (read_hit) begin
      data_out <= {!busy, `LOW_BITS_HIGH};
      data_oe  <= {`DATA_WIDTH{1'b1}};
    end else begin
      data_out <= `BYTE_ZERO;
      data_oe  <= `BYTE_ZERO;
    end
  end

  // ****************************************************************
  // Master parallel addressing
  // ****************************************************************
  logic [`ADDR_LOW_WIDTH+`ADDR_HIGH_WIDTH-1:0] address;
  logic take_master_byte;

  assign take_master_byte = is_master_par && config_clock_rise && !par_loaded;

  always_ff @(posedge clock) begin
    if (sys_rst) address <= `ADDR_ZERO;
    else if (take_master_byte) address <= address + `ADDR_STEP;
  end
  assign eprom_address_low  = address[`ADDR_LOW_WIDTH-1:0];
  assign eprom_address_high = address[`ADDR_LOW_WIDTH+`ADDR_HIGH_WIDTH-1:`ADDR_LOW_WIDTH];
  assign address_low_oe     = is_master_par;
  assign address_high_oe    = is_master_par && WIDE_ADDRESS;

  // ****************************************************************
  // Byte buffer, serialised on falling edges
  // ****************************************************************
  logic [`DATA_WIDTH-1:0] load_byte;
  logic                   load_now;

  assign load_now  = !par_loaded && ((write_edge) || take_master_byte);
  assign load_byte = byte_in;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      par_shift  <= `BYTE_ZERO;
      par_count  <= `BIT_COUNT_ZERO;
      par_loaded <= 1'b0;
    end else if (load_now) begin
      par_shift  <= load_byte;
      par_count  <= `BITS_PER_BYTE;
      par_loaded <= 1'b1;
    end else if (par_loaded && config_clock_fall && is_parallel) begin
      par_shift  <= {1'b0, par_shift[7:1]};
      par_count  <= par_count - 4'h1;
      par_loaded <= par_count != 4'h1;
    end
  end

  // ****************************************************************
  // Serial capture and daisy chain
  // ****************************************************************
  logic din_taken, ser_bit;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      din_taken <= 1'b1;
    end else if (is_serial && config_clock_rise) begin
      din_taken <= din_s;
    end
  end

  // Delay from rising capture to next falling edge plus one period
  logic din_stage;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      din_stage <= 1'b1;
      ser_bit   <= 1'b1;
    end else begin
      if (config_clock_fall) din_stage <= din_taken;
      if (is_express) ser_bit <= express_done;
      else if (config_clock_fall) ser_bit <= is_parallel ? par_shift[0] : din_stage;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      config_byte       <= `BYTE_ZERO;
      config_byte_valid <= 1'b0;
    end else begin
      config_byte_valid <= load_now || (is_express && sel_high_s && config_clock_rise);
      if (load_now) config_byte <= load_byte;
      else if (is_express && sel_high_s && config_clock_rise) config_byte <= byte_in;
    end
  end

  assign serial_out    = ser_bit;
  assign serial_out_oe = active;

  // ****************************************************************
  // Checks
  // ****************************************************************
  status_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
    read_hit |=> data_oe == {`DATA_WIDTH{1'b1}} && data_out[`STATUS_BIT-1:0] == `LOW_BITS_HIGH)
    else $error("status read drive wrong");
  write_wins_a: assert property (@(posedge clock) disable iff (sys_rst)
    (selected && !ws_s && !rs_s) |=> data_oe == `BYTE_ZERO) else $error("read driven during write");
  busy_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    (read_hit && par_loaded) |=> !data_out[`STATUS_BIT]) else $error("ready shown while busy");
  ready_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    (read_hit && !par_loaded) |=> data_out[`STATUS_BIT]) else $error("busy shown while ready");
  unselected_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!selected) |=> data_oe == `BYTE_ZERO) else $error("data driven while unselected");
  write_busy_a: assert property (@(posedge clock) disable iff (sys_rst)
    load_now |=> par_loaded) else $error("write did not set busy");
  address_step_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_master_byte |=> address == $past(address) + `ADDR_STEP) else $error("address not stepped");
  released_a: assert property (@(posedge clock) disable iff (sys_rst)
    config_done |-> !serial_out_oe && !address_low_oe && !address_high_oe) else $error("pins held after done");
  released_data_a: assert property (@(posedge clock) disable iff (sys_rst)
    config_done |=> data_oe == `BYTE_ZERO) else $error("data held after done");
  fall_only_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!is_express && !config_clock_fall) |=> $stable(ser_bit)) else $error("serial out moved off falling edge");
  express_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_express |=> serial_out == $past(express_done)) else $error("express status not shown");
endmodule : config_data_port
`default_nettype wire

//--- test/link_source.sv
// Far side model: configuration clock source
`timescale 1ns/10ps
`default_nettype none
module link_source (
  input  wire logic run,
  output logic      config_clock
);
  initial begin
    config_clock = 1'b0;
  end
  // Stands low between frames, 64 ns period within
  always begin
    wait (run);
    #32 config_clock = 1'b1;
    #32 config_clock = 1'b0;
  end
endmodule : link_source
`default_nettype wire

//--- test/config_data_port_tb.sv
// Self-checking bench for the configuration data port
`timescale 1ns/10ps
`default_nettype none
module config_data_port_tb;
  logic clock = 1'b0, sys_rst = 1'b1, config_done = 1'b0, run = 1'b0, config_clock;
  logic select_low_input = 1'b1, select_high_input = 1'b0, write_strobe_n = 1'b1, read_strobe_n = 1'b1;
  logic serial_in = 1'b1, express_done = 1'b0, serial_out, serial_out_oe, collect = 1'b0;
  logic address_low_oe, address_high_oe, config_byte_valid;
  logic [7:0] data_in = 8'h00, data_out, data_oe, config_byte, b;
  logic [17:0] eprom_address_low;
  logic [3:0] eprom_address_high;
  config_port_pkg::config_mode_type mode = config_port_pkg::MODE_PERIPHERAL;
  logic bits[$], samples[$], expect_q[$];
  int fail_count = 0, checked = 0;
  always #4 clock = ~clock;
  link_source ls (.run(run), .config_clock(config_clock));
  config_data_port dut (.clock(clock), .sys_rst(sys_rst), .mode(mode), .config_done(config_done),
    .config_clock(config_clock), .select_low_input(select_low_input), .select_high_input(select_high_input),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .data_in(data_in), .serial_in(serial_in),
    .express_done(express_done), .data_out(data_out), .data_oe(data_oe), .eprom_address_low(eprom_address_low),
    .address_low_oe(address_low_oe), .eprom_address_high(eprom_address_high), .address_high_oe(address_high_oe),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .config_byte(config_byte),
    .config_byte_valid(config_byte_valid));
  // Serial source presents the next bit after each fall, well before the rise
  always @(negedge config_clock) begin
    if (collect) samples.push_back(serial_out);
    if (bits.size() > 0) serial_in = bits.pop_front();
  end
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (e !== s) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  function automatic bit has_seq();
    int m;
    for (int i = 0; i + expect_q.size() <= samples.size(); i++) begin
      m = 0;
      for (int j = 0; j < expect_q.size(); j++) m += (samples[i+j] === expect_q[j]);
      if (m == expect_q.size()) return 1'b1;
    end
    return 1'b0;
  endfunction : has_seq
  task automatic write_byte(logic [7:0] v, logic both, logic sel);
    int k;
    data_in = v;
    serial_in = v[0];
    select_low_input = 1'b0;
    select_high_input = sel;
    tick(1);
    write_strobe_n = 1'b0;
    read_strobe_n = ~both;
    k = 0;
    while (config_byte_valid !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    chk("capture", sel, config_byte_valid);
    if (sel) chk("config_byte", v, config_byte);
    if (both) chk("data_oe_both", 8'h00, data_oe);
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    tick(1);
  endtask : write_byte
  task automatic frames(int n);
    samples.delete();
    collect = 1'b1;
    run = 1'b1;
    repeat (n) @(posedge config_clock);
    run = 1'b0;
    tick(8);
    collect = 1'b0;
  endtask : frames
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(44513));
    tick(16);
    sys_rst = 1'b0;
    tick(4);
    write_byte(8'hA5, 1'b0, 1'b0);
    for (int t = 0; t < 3; t++) begin
      b = 8'($urandom());
      write_byte(b, t == 2, 1'b1);
      read_strobe_n = 1'b0;
      tick(4);
      chk("status_busy", 16'hFF7F, {data_oe, data_out});
      read_strobe_n = 1'b1;
      frames(12);
      expect_q.delete();
      for (int i = 0; i < 8; i++) expect_q.push_back(b[i]);
      chk("byte_lsb_first", 1, has_seq());
      read_strobe_n = 1'b0;
      tick(4);
      chk("status_ready", 16'hFFFF, {data_oe, data_out});
      read_strobe_n = 1'b1;
      tick(1);
    end
    mode = config_port_pkg::MODE_SLAVE_SERIAL;
    select_high_input = 1'b0;
    expect_q.delete();
    for (int i = 0; i < 16; i++) expect_q.push_back(1'($urandom()));
    bits = expect_q;
    frames(20);
    chk("serial_echo", 1, has_seq());
    chk("serial_oe", 1, serial_out_oe);
    mode = config_port_pkg::MODE_EXPRESS;
    data_in = ~b;
    serial_in = ~b[0];
    frames(2);
    chk("express_gated", b, config_byte);
    b = ~b;
    select_high_input = 1'b1;
    frames(2);
    chk("express_byte", b, config_byte);
    for (int v = 1; v >= 0; v--) begin
      express_done = 1'(v);
      tick(4);
      chk("express_status", v, serial_out);
    end
    mode = config_port_pkg::MODE_MASTER_PARALLEL;
    tick(2);
    chk("address_oe", 2'b11, {address_low_oe, address_high_oe});
    frames(4);
    chk("address_moved", 1, eprom_address_low != 18'h00000);
    chk("address_high", 4'h0, eprom_address_high);
    config_done = 1'b1;
    read_strobe_n = 1'b0;
    select_high_input = 1'b1;
    tick(4);
    chk("released", 11'h000, {data_oe, address_low_oe, address_high_oe, serial_out_oe});
    close_out();
  end
endmodule : config_data_port_tb
`default_nettype wire
